//--- verilog/port_lcd_defines.svh
`ifndef PORT_LCD_DEFINES_SVH
`define PORT_LCD_DEFINES_SVH

// ----------------------------------------
// Register indexes, byte address = 4 x index
// ----------------------------------------
`define IDX_PERIPH_DATA 9'h007
`define IDX_LCD_IO_DATA 9'h008
`define IDX_THIRD_DATA 9'h009
`define IDX_FOURTH_DATA 9'h107
`define IDX_PERIPH_DIR 9'h087
`define IDX_LCD_IO_DIR 9'h088
`define IDX_THIRD_DIR 9'h089
`define IDX_SEGMENT_ENABLE 9'h10d
`define ADDR_IDX_MSB 10
`define ADDR_IDX_LSB 2
`define HSIZE_WORD 3'b010

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_PERIPH_DATA 6'h00
`define RST_PERIPH_DIR 6'h3f
`define RST_LCD_IO_DATA 8'h00
`define RST_LCD_IO_DIR 8'hff
`define RST_THIRD_DIR 8'hff
`define RST_SEGMENT_ENABLE 8'hff

// ----------------------------------------
// Segment group bits of the enable register
// ----------------------------------------
`define GRP_0_4 0
`define GRP_5_8 1
`define GRP_9_11 2
`define GRP_12_15 3
`define GRP_16_19 4
`define GRP_20_26 5
`define GRP_27_28 6
`define GRP_29_31 7

// ----------------------------------------
// Six-bit port pin functions
// ----------------------------------------
`define PIN_TIMER_OSC_OUT 0
`define PIN_TIMER_OSC_IN 1
`define PIN_CAPTURE 2
`define PIN_SERIAL_CLOCK 3
`define PIN_SERIAL_DATA 4
`define PIN_SERIAL_OUT 5

`endif

//--- verilog/port_lcd_pkg.sv
package port_lcd_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [31:0] segment_vec_t;
	typedef logic [8:0] reg_idx_t;
	// Bus slave states, Gray along idle to read wait
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_READ_WAIT = 2'b01
	} bus_state_e;
endpackage

//--- verilog/reg_access_if.sv
`timescale 1ns/1ps
// Register access between the bus slave and the register file
interface reg_access_if;
	logic wr_en;
	port_lcd_pkg::reg_idx_t wr_idx;
	port_lcd_pkg::byte_t wr_data;
	port_lcd_pkg::reg_idx_t rd_idx;
	port_lcd_pkg::byte_t rd_data;
	modport bus (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
	modport regs (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface

//--- verilog/ahb_reg_slave.sv
`timescale 1ns/1ps
`include "port_lcd_defines.svh"

module ahb_reg_slave (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	reg_access_if.bus regs
);
	port_lcd_pkg::bus_state_e state;
	port_lcd_pkg::reg_idx_t idx_q;
	logic hit_q;
	logic wr_pend;
	logic take;

	// NONSEQ or SEQ accepted only while the bus is ready
	assign take = i_hsel & i_htrans[1] & i_hready;

	// Address phase capture; addresses above the map are unmapped
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			idx_q <= 9'h000;
			hit_q <= 1'b0;
			wr_pend <= 1'b0;
		end else begin
			wr_pend <= take & i_hwrite & (i_hsize == `HSIZE_WORD);
			if (take) begin
				idx_q <= i_haddr[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
				hit_q <= (i_haddr[31:`ADDR_IDX_MSB + 1] == 21'h000000);
			end
		end
	end

	// Writes land at the edge that ends the zero-wait data phase
	assign regs.wr_en = wr_pend & hit_q;
	assign regs.wr_idx = idx_q;
	assign regs.wr_data = i_hwdata[7:0];
	assign regs.rd_idx = idx_q;

	// One wait state on reads so a read right after a write sees it
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= port_lcd_pkg::BUS_IDLE;
			o_hreadyout <= 1'b1;
			o_hrdata <= 32'h0000_0000;
			o_hresp <= 1'b0;
		end else begin
			o_hresp <= 1'b0;
			case (state)
				port_lcd_pkg::BUS_IDLE: begin
					if (take && !i_hwrite) begin
						state <= port_lcd_pkg::BUS_READ_WAIT;
						o_hreadyout <= 1'b0;
					end
				end
				default: begin
					o_hrdata <= hit_q ? {24'h00_0000, regs.rd_data} : 32'h0000_0000;
					o_hreadyout <= 1'b1;
					state <= port_lcd_pkg::BUS_IDLE;
				end
			endcase
		end
	end
endmodule

//--- verilog/port_pin_drive.sv
`timescale 1ns/1ps

module port_pin_drive #(
	parameter int W = 6
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [W-1:0] i_drive_en,
	input wire logic [W-1:0] i_latch,
	input wire logic [W-1:0] i_ovr_oe,
	input wire logic [W-1:0] i_ovr_val,
	input wire logic [W-1:0] i_force_in,
	output logic [W-1:0] o_pin,
	output logic [W-1:0] o_pin_oe_n
);
	// Peripheral drive wins over the latch; a forced input wins over both
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pin <= '0;
			o_pin_oe_n <= '1;
		end else begin
			o_pin <= (i_ovr_oe & i_ovr_val) | (~i_ovr_oe & i_latch);
			o_pin_oe_n <= ~((i_ovr_oe | i_drive_en) & ~i_force_in);
		end
	end
endmodule

//--- verilog/port_lcd_segment_pin_mux.sv
`timescale 1ns/1ps
`include "port_lcd_defines.svh"
// What this block does
// [R1] Six-bit port upper two bits read zero
// [R2] Six-bit direction resets to all inputs
// [R3] Pins 0,1 serve timer oscillator and clock
// [R4] Pin 2 serves capture, compare or PWM
// [R5] Pins 3,4,5 serve serial clock, data, out
// [R6] LCD port pins 0-4 are I/O or segment
// [R7] LCD port pins 0-4 map segments 0-4
// [R8] LCD port pins 5-7 never drive digitally
// [R9] Pins 5-7 map segments 29-31 or commons 3-1
// [R10] Direction acts on pins 0-4 in digital only
// [R11] Shared pins start as LCD drivers
// [R12] Set segment enable overrides direction bits
// [R13] Third port is input-only, LCD shared
// [R14] Third port pins 0-6 map segments 5-11
// [R15] Third port pin 7 is segment 27, optional
// [R16] Fourth port is input-only, LCD shared
// [R17] Direction one floats, zero drives latch
// [R18] Data read gives pins, write sets latch
// [R19] Fourth port pins map segments 12-19
// [R20] Enable bits cover contiguous segment groups
// [R21] LCD-shared data reads zero, enables set after reset

module port_lcd_segment_pin_mux (
	input wire logic I_CORE_CLK,
	input wire logic I_RST_N,
	input wire logic I_HSEL,
	input wire logic [31:0] I_HADDR,
	input wire logic [1:0] I_HTRANS,
	input wire logic I_HWRITE,
	input wire logic [2:0] I_HSIZE,
	input wire logic [31:0] I_HWDATA,
	input wire logic I_HREADY,
	output logic [31:0] O_HRDATA,
	output logic O_HREADYOUT,
	output logic O_HRESP,
	input wire logic [5:0] I_PERIPH_PIN,
	output logic [5:0] O_PERIPH_PIN,
	output logic [5:0] O_PERIPH_PIN_OE_N,
	input wire logic I_TIMER_OSC_EN,
	input wire logic I_TIMER_OSC_OUT,
	output logic O_TIMER_OSC_IN,
	output logic O_TIMER_EXT_CLOCK_IN,
	input wire logic I_CAPTURE_COMPARE_PWM_OE,
	input wire logic I_CAPTURE_COMPARE_PWM_OUT,
	output logic O_CAPTURE_COMPARE_PWM_IN,
	input wire logic I_SERIAL_CLOCK_OE,
	input wire logic I_SERIAL_CLOCK_OUT,
	output logic O_SERIAL_CLOCK_IN,
	input wire logic I_SERIAL_DATA_OE,
	input wire logic I_SERIAL_DATA_OUT,
	output logic O_SERIAL_DATA_IN,
	input wire logic I_SERIAL_OUT_OE,
	input wire logic I_SERIAL_OUT,
	input wire logic [7:0] I_LCD_IO_PIN,
	output logic [4:0] O_LCD_IO_PIN,
	output logic [4:0] O_LCD_IO_PIN_OE_N,
	input wire logic [7:0] I_THIRD_PIN,
	input wire logic [7:0] I_FOURTH_PIN,
	input wire logic I_PACKAGE_64PIN,
	input wire logic [1:0] I_LCD_COMMONS_USED,
	output logic [31:0] O_LCD_SEGMENT_DRIVER_SEL,
	output logic [3:1] O_LCD_COMMON_DRIVER_SEL
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic rst_meta;
	logic rst_n;
	logic strap_taken;
	logic pkg_64pin;
	logic [5:0] periph_latch;
	logic [5:0] periph_dir;
	logic [7:0] lcd_io_latch;
	logic [7:0] lcd_io_dir;
	logic [7:0] third_dir;
	port_lcd_pkg::byte_t segment_enable;
	logic [5:0] periph_pin_q;
	logic [7:0] lcd_io_pin_q;
	logic [7:0] third_pin_q;
	logic [7:0] fourth_pin_q;
	port_lcd_pkg::segment_vec_t segment_on;
	logic [7:0] lcd_io_digital;
	logic [7:0] third_digital;
	logic [7:0] fourth_digital;
	logic [3:1] common_need;
	logic [5:0] periph_ovr_oe;
	logic [5:0] periph_ovr_val;
	logic [5:0] periph_force_in;
	logic [4:0] lcd_io_drive_en;
	port_lcd_pkg::byte_t rd_mux;

	reg_access_if regs_if ();

	// ----------------------------------------
	// Helpers
	// ----------------------------------------

	// Spread the eight group enables over the 32 segment drivers
	function automatic port_lcd_pkg::segment_vec_t segment_expand(
		input port_lcd_pkg::byte_t en,
		input logic small_pkg
	);
		port_lcd_pkg::segment_vec_t v;
		v = 32'h0000_0000;
		// [R20] group to segment spread
		v[4:0] = {5{en[`GRP_0_4]}};
		v[8:5] = {4{en[`GRP_5_8]}};
		v[11:9] = {3{en[`GRP_9_11]}};
		v[15:12] = {4{en[`GRP_12_15]}};
		v[19:16] = {4{en[`GRP_16_19]}};
		v[26:20] = {7{en[`GRP_20_26]}};
		// [R15] small package lacks these pins
		v[28:27] = {2{en[`GRP_27_28] & ~small_pkg}};
		v[31:29] = {3{en[`GRP_29_31]}};
		return v;
	endfunction

	// Write strobe for one register index
	function automatic logic reg_write(
		input logic en,
		input port_lcd_pkg::reg_idx_t at,
		input port_lcd_pkg::reg_idx_t idx
	);
		return en && (at == idx);
	endfunction

	// ----------------------------------------
	// Reset release
	// ----------------------------------------

	// Assert at once, release two edges later to avoid a ragged release
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// Package strap caught once after release, held until next reset
	always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			strap_taken <= 1'b0;
			pkg_64pin <= 1'b0;
		end else if (!strap_taken) begin
			strap_taken <= 1'b1;
			pkg_64pin <= I_PACKAGE_64PIN;
		end
	end

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	ahb_reg_slave u_bus (
		.i_clk(I_CORE_CLK),
		.i_rst_n(rst_n),
		.i_hsel(I_HSEL),
		.i_haddr(I_HADDR),
		.i_htrans(I_HTRANS),
		.i_hwrite(I_HWRITE),
		.i_hsize(I_HSIZE),
		.i_hwdata(I_HWDATA),
		.i_hready(I_HREADY),
		.o_hrdata(O_HRDATA),
		.o_hreadyout(O_HREADYOUT),
		.o_hresp(O_HRESP),
		.regs(regs_if)
	);

	// ----------------------------------------
	// Software registers
	// ----------------------------------------

	// Six-bit port latch and direction; only bits 5..0 exist
	always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			periph_latch <= `RST_PERIPH_DATA;
			// [R2] all pins input after reset
			periph_dir <= `RST_PERIPH_DIR;
		end else begin
			// [R18] write updates latch
			if (reg_write(regs_if.wr_en, regs_if.wr_idx, `IDX_PERIPH_DATA)) begin
				periph_latch <= regs_if.wr_data[5:0];
			end
			if (reg_write(regs_if.wr_en, regs_if.wr_idx, `IDX_PERIPH_DIR)) begin
				periph_dir <= regs_if.wr_data[5:0];
			end
		end
	end

	// LCD-shared port latch and direction, all eight bits stored
	always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			lcd_io_latch <= `RST_LCD_IO_DATA;
			lcd_io_dir <= `RST_LCD_IO_DIR;
		end else begin
			if (reg_write(regs_if.wr_en, regs_if.wr_idx, `IDX_LCD_IO_DATA)) begin
				lcd_io_latch <= regs_if.wr_data;
			end
			if (reg_write(regs_if.wr_en, regs_if.wr_idx, `IDX_LCD_IO_DIR)) begin
				lcd_io_dir <= regs_if.wr_data;
			end
		end
	end

	// Third port direction is storage only; the port cannot drive
	always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			third_dir <= `RST_THIRD_DIR;
		end else if (reg_write(regs_if.wr_en, regs_if.wr_idx, `IDX_THIRD_DIR)) begin
			third_dir <= regs_if.wr_data;
		end
	end

	// Segment enables, all set so every shared pin starts on the panel
	always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			// [R11] LCD mode after reset
			segment_enable <= `RST_SEGMENT_ENABLE;
		end else if (reg_write(regs_if.wr_en, regs_if.wr_idx, `IDX_SEGMENT_ENABLE)) begin
			segment_enable <= regs_if.wr_data;
		end
	end

	// ----------------------------------------
	// Pin sampling
	// ----------------------------------------

	// One sampling stage shared by reads and peripheral inputs
	always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			periph_pin_q <= 6'h00;
			lcd_io_pin_q <= 8'h00;
			third_pin_q <= 8'h00;
			fourth_pin_q <= 8'h00;
		end else begin
			periph_pin_q <= I_PERIPH_PIN;
			lcd_io_pin_q <= I_LCD_IO_PIN;
			third_pin_q <= I_THIRD_PIN;
			fourth_pin_q <= I_FOURTH_PIN;
		end
	end

	// Peripheral inputs follow the sampled pins whatever the direction
	// [R3] timer oscillator and clock input
	assign O_TIMER_EXT_CLOCK_IN = periph_pin_q[`PIN_TIMER_OSC_OUT];
	assign O_TIMER_OSC_IN = periph_pin_q[`PIN_TIMER_OSC_IN];
	// [R4] capture input path
	assign O_CAPTURE_COMPARE_PWM_IN = periph_pin_q[`PIN_CAPTURE];
	// [R5] serial clock and data in
	assign O_SERIAL_CLOCK_IN = periph_pin_q[`PIN_SERIAL_CLOCK];
	assign O_SERIAL_DATA_IN = periph_pin_q[`PIN_SERIAL_DATA];

	// ----------------------------------------
	// Pin mode per segment group
	// ----------------------------------------
	assign segment_on = segment_expand(segment_enable, pkg_64pin);

	// A pin is digital only while its segment driver is off
	always_comb begin
		// [R12] set enable means LCD mode
		// [R7] pins 0-4 to segments 0-4
		lcd_io_digital[4:0] = ~segment_on[4:0];
		// [R9] pins 5-7 to segments 29-31
		lcd_io_digital[7:5] = ~segment_on[31:29];
		// [R14] pins 0-6 to segments 5-11
		third_digital[6:0] = ~segment_on[11:5];
		// [R15] pin 7 is segment 27, absent on small package
		third_digital[7] = ~segment_enable[`GRP_27_28] & ~pkg_64pin;
		// [R19] pins to segments 12-19
		fourth_digital = ~segment_on[19:12];
	end

	// Commons needed by the multiplex ratio, highest common on pin 5
	always_comb begin
		common_need[1] = (I_LCD_COMMONS_USED >= 2'd1);
		common_need[2] = (I_LCD_COMMONS_USED >= 2'd2);
		common_need[3] = (I_LCD_COMMONS_USED == 2'd3);
	end

	// Panel routing registered so the LCD side sees clean selects
	always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			O_LCD_SEGMENT_DRIVER_SEL <= 32'h0000_0000;
			O_LCD_COMMON_DRIVER_SEL <= 3'h0;
		end else begin
			// [R9] a common takes the pin from its segment
			O_LCD_COMMON_DRIVER_SEL <= {3{segment_enable[`GRP_29_31]}} & common_need;
			// Common 1 sits on segment 31, common 3 on segment 29
			O_LCD_SEGMENT_DRIVER_SEL <= segment_on
				& ~{common_need[1], common_need[2], common_need[3], 29'h0000_0000};
		end
	end

	// ----------------------------------------
	// Six-bit peripheral port drivers
	// ----------------------------------------

	// Peripherals take over the pin driver while they are enabled
	always_comb begin
		periph_ovr_oe = 6'h00;
		periph_ovr_val = 6'h00;
		periph_force_in = 6'h00;
		// [R3] oscillator owns pins 0 and 1
		periph_ovr_oe[`PIN_TIMER_OSC_OUT] = I_TIMER_OSC_EN;
		periph_ovr_val[`PIN_TIMER_OSC_OUT] = I_TIMER_OSC_OUT;
		periph_force_in[`PIN_TIMER_OSC_IN] = I_TIMER_OSC_EN;
		// [R4] compare or PWM output
		periph_ovr_oe[`PIN_CAPTURE] = I_CAPTURE_COMPARE_PWM_OE;
		periph_ovr_val[`PIN_CAPTURE] = I_CAPTURE_COMPARE_PWM_OUT;
		// [R5] serial clock, data and data out
		periph_ovr_oe[`PIN_SERIAL_CLOCK] = I_SERIAL_CLOCK_OE;
		periph_ovr_val[`PIN_SERIAL_CLOCK] = I_SERIAL_CLOCK_OUT;
		periph_ovr_oe[`PIN_SERIAL_DATA] = I_SERIAL_DATA_OE;
		periph_ovr_val[`PIN_SERIAL_DATA] = I_SERIAL_DATA_OUT;
		periph_ovr_oe[`PIN_SERIAL_OUT] = I_SERIAL_OUT_OE;
		periph_ovr_val[`PIN_SERIAL_OUT] = I_SERIAL_OUT;
	end

	// [R17] zero direction drives latch
	port_pin_drive #(
		.W(6)
	) u_periph_drive (
		.i_clk(I_CORE_CLK),
		.i_rst_n(rst_n),
		.i_drive_en(~periph_dir),
		.i_latch(periph_latch),
		.i_ovr_oe(periph_ovr_oe),
		.i_ovr_val(periph_ovr_val),
		.i_force_in(periph_force_in),
		.o_pin(O_PERIPH_PIN),
		.o_pin_oe_n(O_PERIPH_PIN_OE_N)
	);

	// ----------------------------------------
	// LCD-shared port drivers
	// ----------------------------------------

	// Only pins 0-4 have a driver; an LCD pin never drives digitally
	// [R10] direction only in digital mode
	// [R6] I/O or segment per pin
	assign lcd_io_drive_en = ~lcd_io_dir[4:0] & lcd_io_digital[4:0];

	// [R8] upper pins have no driver
	port_pin_drive #(
		.W(5)
	) u_lcd_io_drive (
		.i_clk(I_CORE_CLK),
		.i_rst_n(rst_n),
		.i_drive_en(lcd_io_drive_en),
		.i_latch(lcd_io_latch[4:0]),
		.i_ovr_oe(5'h00),
		.i_ovr_val(5'h00),
		.i_force_in(5'h00),
		.o_pin(O_LCD_IO_PIN),
		.o_pin_oe_n(O_LCD_IO_PIN_OE_N)
	);

	// ----------------------------------------
	// Register read
	// ----------------------------------------

	// Data reads give pin levels; pins still on the panel read zero
	always_comb begin
		rd_mux = 8'h00;
		if (regs_if.rd_idx == `IDX_PERIPH_DATA) begin
			// [R1] upper bits read zero
			rd_mux = {2'b00, periph_pin_q};
		end else if (regs_if.rd_idx == `IDX_PERIPH_DIR) begin
			rd_mux = {2'b00, periph_dir};
		end else if (regs_if.rd_idx == `IDX_LCD_IO_DATA) begin
			// [R21] LCD pins read zero
			rd_mux = lcd_io_pin_q & lcd_io_digital;
		end else if (regs_if.rd_idx == `IDX_LCD_IO_DIR) begin
			rd_mux = lcd_io_dir;
		end else if (regs_if.rd_idx == `IDX_THIRD_DATA) begin
			// [R13] input-only read path
			rd_mux = third_pin_q & third_digital;
		end else if (regs_if.rd_idx == `IDX_THIRD_DIR) begin
			rd_mux = third_dir;
		end else if (regs_if.rd_idx == `IDX_FOURTH_DATA) begin
			// [R16] input-only read path
			rd_mux = fourth_pin_q & fourth_digital;
		end else if (regs_if.rd_idx == `IDX_SEGMENT_ENABLE) begin
			rd_mux = segment_enable;
		end
	end

	assign regs_if.rd_data = rd_mux;

endmodule

//--- verif/port_lcd_segment_pin_mux_checker.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port and segment mux checker
// ----------------------------------------
module port_lcd_segment_pin_mux_checker (
	input wire logic I_CORE_CLK,
	input wire logic I_RST_N,
	input wire logic I_HSEL,
	input wire logic [31:0] I_HADDR,
	input wire logic [1:0] I_HTRANS,
	input wire logic I_HWRITE,
	input wire logic [2:0] I_HSIZE,
	input wire logic [31:0] I_HWDATA,
	input wire logic I_HREADY,
	input wire logic [31:0] O_HRDATA,
	input wire logic O_HREADYOUT,
	input wire logic O_HRESP,
	input wire logic [5:0] O_PERIPH_PIN,
	input wire logic [5:0] O_PERIPH_PIN_OE_N,
	input wire logic I_TIMER_OSC_EN,
	input wire logic I_TIMER_OSC_OUT,
	input wire logic [4:0] O_LCD_IO_PIN_OE_N,
	input wire logic I_PACKAGE_64PIN,
	input wire logic [1:0] I_LCD_COMMONS_USED,
	input wire logic [31:0] O_LCD_SEGMENT_DRIVER_SEL,
	input wire logic [3:1] O_LCD_COMMON_DRIVER_SEL
);
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RST_N);
	logic take, pend, pk;
	logic [8:0] at, wat;
	logic [7:0] se, ldir;
	logic [1:0] up;
	logic [3:1] lcd_common_driver;
	logic [31:0] lcd_segment_driver;
	logic [4:0] lcd_oe;

	// Accepted transfer and its register index
	assign take = I_HSEL && I_HTRANS[1] && I_HREADY;
	assign at = I_HADDR[10:2];
	// Shadow control registers; up waits out the reset synchroniser
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			pend <= 1'b0;
			wat <= 9'h000;
			se <= 8'hff;
			ldir <= 8'hff;
			up <= 2'd0;
			pk <= 1'b0;
		end else begin
			if (up != 2'd3)
				up <= up + 2'd1;
			// Strap is caught once, on the first edge out of internal reset
			if (up == 2'd2)
				pk <= I_PACKAGE_64PIN;
			if (I_HREADY) begin
				pend <= take && I_HWRITE && I_HSIZE == 3'b010 && I_HADDR[31:11] == 21'h0;
				wat <= at;
			end
			if (pend && wat == 9'h10d)
				se <= I_HWDATA[7:0];
			if (pend && wat == 9'h088)
				ldir <= I_HWDATA[7:0];
		end
	end
	// Expected selects; commons only claim their pins while group 29-31 is LCD
	assign lcd_common_driver = se[7] ? {I_LCD_COMMONS_USED == 2'd3, I_LCD_COMMONS_USED[1],
		I_LCD_COMMONS_USED != 2'd0} : 3'b000;
	assign lcd_segment_driver = {{3{se[7]}} & ~{lcd_common_driver[1], lcd_common_driver[2], lcd_common_driver[3]}, {2{se[6] & !pk}},
		{7{se[5]}}, {4{se[4]}}, {4{se[3]}}, {3{se[2]}}, {4{se[1]}}, {5{se[0]}}};
	assign lcd_oe = se[0] ? 5'h1f : ldir[4:0];

	AST_RESP_OKAY: assert property (O_HRESP == 1'b0)
		else $error("bus response not OKAY");
	AST_READ_ONE_WAIT: assert property (take && !I_HWRITE |=> !O_HREADYOUT ##1 O_HREADYOUT)
		else $error("read wait state wrong");
	AST_WRITE_NO_WAIT: assert property (take && I_HWRITE |=> O_HREADYOUT)
		else $error("write stalled");
	AST_PERIPH_HIGH_ZERO: assert property (
		take && !I_HWRITE && (at == 9'h007 || at == 9'h087) |-> ##2 O_HRDATA[31:6] == 26'h0)
		else $error("six-bit port upper bits not zero");
	AST_RESET_STATE: assert property (disable iff (1'b0) !I_RST_N |=>
		O_PERIPH_PIN_OE_N == 6'h3f && O_LCD_IO_PIN_OE_N == 5'h1f && O_LCD_SEGMENT_DRIVER_SEL == '0)
		else $error("pins driven during reset");
	AST_SEGMENT_GROUPS: assert property (up == 2'd3 |-> O_LCD_SEGMENT_DRIVER_SEL == $past(lcd_segment_driver))
		else $error("segment select differs from enable groups");
	AST_COMMON_SELECT: assert property (up == 2'd3 |-> O_LCD_COMMON_DRIVER_SEL == $past(lcd_common_driver))
		else $error("common select wrong");
	AST_LCD_DIRECTION: assert property (up == 2'd3 |-> O_LCD_IO_PIN_OE_N == $past(lcd_oe))
		else $error("LCD port drive enable wrong");
	AST_OSC_PINS: assert property (up == 2'd3 && $past(I_TIMER_OSC_EN) |->
		O_PERIPH_PIN_OE_N[1:0] == 2'b10 && O_PERIPH_PIN[0] == $past(I_TIMER_OSC_OUT))
		else $error("oscillator pins wrong");

	COV_READ_LCD: cover property (take && !I_HWRITE && at == 9'h008);
	COV_DIGITAL_DRIVE: cover property (up == 2'd3 && lcd_oe != 5'h1f);
	COV_OSC: cover property (up == 2'd3 && I_TIMER_OSC_EN);
endmodule

bind port_lcd_segment_pin_mux port_lcd_segment_pin_mux_checker u_chk (
	.I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N), .I_HSEL(I_HSEL), .I_HADDR(I_HADDR),
	.I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HSIZE(I_HSIZE), .I_HWDATA(I_HWDATA),
	.I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP),
	.O_PERIPH_PIN(O_PERIPH_PIN), .O_PERIPH_PIN_OE_N(O_PERIPH_PIN_OE_N),
	.I_TIMER_OSC_EN(I_TIMER_OSC_EN), .I_TIMER_OSC_OUT(I_TIMER_OSC_OUT),
	.O_LCD_IO_PIN_OE_N(O_LCD_IO_PIN_OE_N), .I_PACKAGE_64PIN(I_PACKAGE_64PIN),
	.I_LCD_COMMONS_USED(I_LCD_COMMONS_USED), .O_LCD_SEGMENT_DRIVER_SEL(O_LCD_SEGMENT_DRIVER_SEL),
	.O_LCD_COMMON_DRIVER_SEL(O_LCD_COMMON_DRIVER_SEL)
);

//--- verif/pin_partner_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Board side of the port pins
// ----------------------------------------
module pin_partner_model (
	input wire logic [5:0] i_per_drv,
	input wire logic [5:0] i_per_oe_n,
	input wire logic [4:0] i_lcd_drv,
	input wire logic [4:0] i_lcd_oe_n,
	input wire logic [5:0] i_per_ext,
	input wire logic [7:0] i_lcd_ext,
	output logic [5:0] o_per_pin,
	output logic [7:0] o_lcd_pin
);
	// driver wins pin
	// No pulls: a released pin shows the outside level, which the bench keeps moving
	assign o_per_pin = (i_per_drv & ~i_per_oe_n) | (i_per_ext & i_per_oe_n);
	assign o_lcd_pin = {i_lcd_ext[7:5], (i_lcd_drv & ~i_lcd_oe_n) | (i_lcd_ext[4:0] & i_lcd_oe_n)};
endmodule

//--- verif/port_lcd_segment_pin_mux_test.sv
`timescale 1ns/1ps
module port_lcd_segment_pin_mux_test;
	logic clk, rst_n, hwrite, hrdy, pk;
	wire [4:0] pin_in;
	logic [1:0] htrans, comm;
	logic [31:0] haddr, hwdata, hrdata;
	logic [5:0] per_drv, per_oe_n, per_pin, ext_p, pdat, pdir;
	logic [4:0] lcd_drv, lcd_oe_n;
	logic [7:0] lcd_pin, ext_l, ext_t, ext_f, ldat, ldir, tdir, se, q;
	logic [9:0] pe;
	int mismatches = 0;
	int n_tests = 0;
	int i, a;
	int idxs[$];

	port_lcd_segment_pin_mux u_dut (
		.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_HSEL(1'b1), .I_HADDR(haddr), .I_HTRANS(htrans),
		.I_HWRITE(hwrite), .I_HSIZE(3'b010), .I_HWDATA(hwdata), .I_HREADY(hrdy),
		.O_HRDATA(hrdata), .O_HREADYOUT(hrdy), .O_HRESP(), .I_PERIPH_PIN(per_pin),
		.O_PERIPH_PIN(per_drv), .O_PERIPH_PIN_OE_N(per_oe_n), .I_TIMER_OSC_EN(pe[0]),
		.I_TIMER_OSC_OUT(pe[1]), .O_TIMER_OSC_IN(pin_in[1]), .O_TIMER_EXT_CLOCK_IN(pin_in[0]),
		.I_CAPTURE_COMPARE_PWM_OE(pe[2]), .I_CAPTURE_COMPARE_PWM_OUT(pe[3]),
		.O_CAPTURE_COMPARE_PWM_IN(pin_in[2]), .I_SERIAL_CLOCK_OE(pe[4]),
		.I_SERIAL_CLOCK_OUT(pe[5]),
		.O_SERIAL_CLOCK_IN(pin_in[3]), .I_SERIAL_DATA_OE(pe[6]), .I_SERIAL_DATA_OUT(pe[7]),
		.O_SERIAL_DATA_IN(pin_in[4]), .I_SERIAL_OUT_OE(pe[8]), .I_SERIAL_OUT(pe[9]),
		.I_LCD_IO_PIN(lcd_pin), .O_LCD_IO_PIN(lcd_drv), .O_LCD_IO_PIN_OE_N(lcd_oe_n),
		.I_THIRD_PIN(ext_t), .I_FOURTH_PIN(ext_f), .I_PACKAGE_64PIN(pk),
		.I_LCD_COMMONS_USED(comm), .O_LCD_SEGMENT_DRIVER_SEL(), .O_LCD_COMMON_DRIVER_SEL()
	);
	pin_partner_model u_pins (
		.i_per_drv(per_drv), .i_per_oe_n(per_oe_n), .i_lcd_drv(lcd_drv),
		.i_lcd_oe_n(lcd_oe_n), .i_per_ext(ext_p), .i_lcd_ext(ext_l),
		.o_per_pin(per_pin), .o_lcd_pin(lcd_pin)
	);

	// ----------------------------------------
	// Clock, watchdog and verdict
	// ----------------------------------------
	always #2 clk = ~clk;
	// The run needs about 1000 cycles; 100 us is ample
	initial begin
		#100000;
		mismatches++;
		test_done();
	end
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t read %h expected %h", $time, seen, exp);
		end
	endtask

	// ----------------------------------------
	// Bus master and register model
	// ----------------------------------------
	// Single transfer; each phase holds until hready is sampled high
	task automatic bus(input logic w, input int idx, input logic [7:0] d);
		int n;
		n = 0;
		haddr <= {21'h0, 9'(idx), 2'b00};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge clk); while (hrdy !== 1'b1 && ++n < 50);
		htrans <= 2'b00;
		hwdata <= {24'($urandom), d};
		do @(posedge clk); while (hrdy !== 1'b1 && ++n < 50);
		q = hrdata[7:0];
		if (n >= 50)
			mismatches++;
	endtask
	task automatic wr(input int idx, input logic [7:0] d);
		bus(1'b1, idx, d);
		case (idx)
			'h007: pdat = d[5:0];
			'h008: ldat = d;
			'h087: pdir = d[5:0];
			'h088: ldir = d;
			'h089: tdir = d;
			'h10d: se = d;
			default: ;
		endcase
	endtask
	function automatic logic [7:0] model(input int idx);
		case (idx)
			'h007: return {2'b00, (pdir & ext_p) | (~pdir & pdat)};
			'h008: return {se[7] ? 3'h0 : ext_l[7:5],
				se[0] ? 5'h00 : (ldir[4:0] & ext_l[4:0]) | (~ldir[4:0] & ldat[4:0])};
			'h009: return ext_t & ~{se[6] | pk, {3{se[2]}}, {4{se[1]}}};
			'h107: return ext_f & ~{{4{se[4]}}, {4{se[3]}}};
			'h087: return {2'b00, pdir};
			'h088: return ldir;
			'h089: return tdir;
			'h10d: return se;
			default: return 8'h00;
		endcase
	endfunction
	// Six-bit port pins: peripheral drive, else latch by direction, osc frees pin 1
	function automatic logic [7:0] pexp();
		logic [5:0] po, pv, dr;
		po = {pe[8], pe[6], pe[4], pe[2], 1'b0, pe[0]};
		pv = (po & {pe[9], pe[7], pe[5], pe[3], 1'b0, pe[1]}) | (~po & pdat);
		dr = (po | ~pdir) & ~{4'h0, pe[0], 1'b0};
		return {2'b00, (dr & pv) | (~dr & ext_p)};
	endfunction
	task automatic rd(input int idx);
		bus(1'b0, idx, 8'h00);
		chk(q, model(idx));
	endtask
	task automatic pulse(input int n);
		rst_n <= 1'b0;
		repeat (n) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		{pdat, ldat} = '0;
		{pdir, ldir, tdir, se} = {6'h3f, 24'hffffff};
		foreach (idxs[k])
			rd(idxs[k]);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{clk, rst_n, hwrite, htrans, haddr, hwdata, pe} = '0;
		{ext_p, ext_l, ext_t, ext_f, comm, pk} = '0;
		a = $urandom(80);
		idxs = '{'h007, 'h008, 'h009, 'h107, 'h087, 'h088, 'h089, 'h10d, 'h1ff};
		pulse(8);
		for (i = 0; i < 80; i++) begin
			{ext_p, ext_l, ext_t, ext_f, comm} <= 32'($urandom);
			a = idxs[$urandom_range(8)];
			wr(a, 8'($urandom));
			if (a inside {'h087, 'h088, 'h089, 'h10d})
				rd(a);
			repeat (4) @(posedge clk);
			rd(idxs[$urandom_range(8)]);
		end
		for (i = 0; i < 40; i++) begin
			pe <= 10'($urandom);
			repeat (3) @(posedge clk);
			chk({2'b00, per_pin[5], pin_in}, pexp());
		end
		pe <= 10'h000;
		// small package strap drops third port pin 7
		{pk, ext_t} <= 9'h1ff;
		pulse(3);
		wr('h10d, 8'h00);
		rd('h009);
		test_done();
	end
endmodule
